/* File: rtl/adc_serial_regs.vh */
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH

// Result and channel-select widths
`define RES_W 10
`define CODE_W 4
`define RES_MSB 9

// Channel multiplexer
`define NUM_CHANNELS 14
`define NUM_EXT_INPUTS 11

// Shift-clock edge numbers within one access
`define CODE_BITS 4'h4
`define SAMPLE_EDGE 4'h4
`define LAST_DATA_EDGE 4'h9
`define HANDOFF_EDGE 4'hA
`define EDGE_CNT_MAX 4'hF

// Timing: successive-approximation step period
`define CLK_MHZ 20
`define SAR_STEP_NS 200
`define SAR_STEP_CYC ((`SAR_STEP_NS * `CLK_MHZ) / 1000)
`define STEP_CNT_W 3

// Result buffer
`define RES_FIFO_DEPTH 8
`define RES_FIFO_AW 3

// Reset values
`define RES_RESET 10'h000
`define CODE_RESET 4'h0

`endif

/* File: rtl/result_fifo.v */
module result_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // result_fifo

/* File: rtl/adc_serial_if.v */
`include "adc_serial_regs.vh"

// Operation
// (R01) Four code bits, MSB first, rising edges
// (R02) Code input ignored after four bits
// (R03) Code steers fourteen-channel input multiplexer
// (R04) Select fall resets counters, enables pins
// (R05) Select rise stops accepting clock, code
// (R06) Serial output driven only while selected
// (R07) Select valid presents previous result MSB
// (R08) Falling edges shift next bits, LSB ninth
// (R09) Tenth falling edge forces output low
// (R10) End-of-conversion low from tenth edge
// (R11) End-of-conversion rises when result ready
// (R12) Ten-bit successive approximation, read next access
// (R13) Sample edges four to ten, then convert
// (R14) Host gives ten to sixteen clocks
// (R15) Continuous select: MSB on conversion end
// (R16) Shift clock and select synchronised first
// (R17) Result held until next access
module adc_serial_if (
    input wire clk_in,
    input wire sys_rst_in,
    input wire sel_n_in,
    input wire sclk_in,
    input wire chan_sel_in,
    input wire cmp_in,
    output reg data_out_out,
    output reg data_oe_out,
    output reg eoc_out,
    output reg [`CODE_W-1:0] chan_code_out,
    output reg [`NUM_CHANNELS-1:0] chan_onehot_out,
    output reg sample_out,
    output reg [`RES_W-1:0] dac_code_out,
    output reg conv_busy_out
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_CONV = 2'b01;
    localparam [1:0] ST_PUSH = 2'b10;
    // Integer copies, so the narrow constants are cut on purpose
    localparam integer STEP_CYC = `SAR_STEP_CYC;
    localparam integer MSB_NUM = `RES_MSB;
    localparam [`STEP_CNT_W-1:0] STEP_LAST =
        STEP_CYC[`STEP_CNT_W-1:0] - 1'b1;
    localparam [3:0] MSB_IDX = MSB_NUM[3:0];

    // Two-flop synchronisers, then a history flop for edges
    reg sel_n_meta;
    reg sel_n_sync;
    reg sel_n_prev;
    reg sclk_meta;
    reg sclk_sync;
    reg sclk_prev;
    reg chan_meta;
    reg chan_sync;

    wire sel_active;
    wire sel_fall;
    wire sel_rise;
    wire sclk_rise;
    wire sclk_fall;

    reg [3:0] rise_cnt;
    reg [3:0] fall_cnt;
    reg [`CODE_W-1:0] code_shift;
    reg [`RES_W-1:0] shift_reg;
    reg [`RES_W-1:0] result_hold;

    reg [1:0] state;
    reg [3:0] bit_idx;
    reg [`STEP_CNT_W-1:0] step_cnt;
    reg step_en;
    reg [`RES_W-1:0] sar_result;
    reg conv_start;

    wire fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [`RES_W-1:0] fifo_out_data;
    wire reload;

    wire [`NUM_CHANNELS-1:0] next_onehot;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sel_n_meta <= 1'b1;
            sel_n_sync <= 1'b1;
            sel_n_prev <= 1'b1;
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            chan_meta <= 1'b0;
            chan_sync <= 1'b0;
        end else begin
            sel_n_meta <= sel_n_in; // [R16]
            sel_n_sync <= sel_n_meta;
            sel_n_prev <= sel_n_sync;
            sclk_meta <= sclk_in; // [R16]
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            chan_meta <= chan_sel_in;
            chan_sync <= chan_meta;
        end
    end

    assign sel_active = !sel_n_sync;
    assign sel_fall = sel_n_prev && !sel_n_sync;
    assign sel_rise = !sel_n_prev && sel_n_sync;
    // Clock edges count only while selected and not at select fall
    assign sclk_rise = sel_active && !sel_fall
        && !sclk_prev && sclk_sync; // [R05]
    assign sclk_fall = sel_active && !sel_fall
        && sclk_prev && !sclk_sync; // [R05]

    // New result may replace the held one only while deselected or from the tenth falling edge on,
    // so a word never changes while the host is reading it
    // Select edges own their cycle: the word waits in the buffer
    // rather than being popped and lost
    assign reload = fifo_out_valid && !sel_fall && !sel_rise
        && (!sel_active || fall_cnt >= `HANDOFF_EDGE); // [R17]
    assign fifo_out_ready = reload;

    // Serial access: counters, code capture, data shift
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
            code_shift <= `CODE_RESET;
            chan_code_out <= `CODE_RESET;
            shift_reg <= `RES_RESET;
            result_hold <= `RES_RESET;
            data_out_out <= 1'b0;
            data_oe_out <= 1'b0;
            eoc_out <= 1'b1;
            sample_out <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (sel_fall) begin
                rise_cnt <= 4'h0; // [R04]
                fall_cnt <= 4'h0;
                code_shift <= `CODE_RESET;
                sample_out <= 1'b0;
                shift_reg <= result_hold; // [R07]
                data_out_out <= result_hold[`RES_MSB]; // [R07]
                data_oe_out <= 1'b1; // [R04] [R06]
            end else if (sel_rise) begin
                data_oe_out <= 1'b0; // [R06]
                data_out_out <= 1'b0;
                sample_out <= 1'b0;
            end else if (reload) begin
                result_hold <= fifo_out_data; // [R12]
                shift_reg <= fifo_out_data;
                eoc_out <= 1'b1; // [R11]
                // Longer accesses keep shifting zeros until select rises
                if (sel_active && fall_cnt == `HANDOFF_EDGE) begin
                    // Select held low: next cycle starts here
                    rise_cnt <= 4'h0; // [R15]
                    fall_cnt <= 4'h0;
                    code_shift <= `CODE_RESET;
                    data_out_out <= fifo_out_data[`RES_MSB]; // [R15]
                end
            end else begin
                if (sclk_rise && rise_cnt < `CODE_BITS) begin
                    code_shift <= {code_shift[`CODE_W-2:0],
                        chan_sync}; // [R01] [R02]
                    rise_cnt <= rise_cnt + 4'h1;
                    if (rise_cnt == `CODE_BITS - 4'h1) begin
                        chan_code_out <= {code_shift[`CODE_W-2:0],
                            chan_sync}; // [R03]
                    end
                end
                if (sclk_fall && fall_cnt != `EDGE_CNT_MAX) begin
                    fall_cnt <= fall_cnt + 4'h1; // [R14]
                    if (fall_cnt < `LAST_DATA_EDGE) begin
                        shift_reg <= {shift_reg[`RES_W-2:0], 1'b0};
                        data_out_out <= shift_reg[`RES_MSB-1]; // [R08]
                    end else begin
                        data_out_out <= 1'b0; // [R09]
                    end
                    if (fall_cnt == `SAMPLE_EDGE - 4'h1) begin
                        sample_out <= 1'b1; // [R13]
                    end
                    if (fall_cnt == `HANDOFF_EDGE - 4'h1) begin
                        sample_out <= 1'b0; // [R13]
                        eoc_out <= 1'b0; // [R10]
                        conv_start <= 1'b1; // [R13]
                    end
                end
            end
        end
    end

    // Channel decode: codes beyond the table select nothing
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_dec
            assign next_onehot[ch] = (chan_code_out == ch); // [R03]
        end
    endgenerate

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chan_onehot_out <= {`NUM_CHANNELS{1'b0}};
        end else begin
            chan_onehot_out <= next_onehot; // [R03]
        end
    end

    // Step-rate divider for the approximation sequence
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            step_cnt <= {`STEP_CNT_W{1'b0}};
            step_en <= 1'b0;
        end else if (state != ST_CONV) begin
            step_cnt <= {`STEP_CNT_W{1'b0}};
            step_en <= 1'b0;
        end else if (step_cnt == STEP_LAST) begin
            step_cnt <= {`STEP_CNT_W{1'b0}};
            step_en <= 1'b1;
        end else begin
            step_cnt <= step_cnt + 1'b1;
            step_en <= 1'b0;
        end
    end

    // Successive approximation: one bit per step, MSB first.
    // A full buffer stalls the finished word in ST_PUSH.
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            bit_idx <= 4'h0;
            sar_result <= `RES_RESET;
            dac_code_out <= `RES_RESET;
            conv_busy_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (conv_start) begin
                        state <= ST_CONV; // [R13]
                        bit_idx <= MSB_IDX;
                        sar_result <= `RES_RESET;
                        dac_code_out <= 10'h200; // [R12]
                        conv_busy_out <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (step_en) begin
                        // Comparator high keeps the trial bit
                        sar_result[bit_idx] <= cmp_in; // [R12]
                        if (bit_idx == 4'h0) begin
                            state <= ST_PUSH;
                            dac_code_out <= `RES_RESET;
                        end else begin
                            bit_idx <= bit_idx - 4'h1;
                            dac_code_out <= (dac_code_out
                                & ~(10'h001 << bit_idx))
                                | ({9'h000, cmp_in} << bit_idx)
                                | (10'h001 << (bit_idx - 4'h1));
                        end
                    end
                end
                ST_PUSH: begin
                    if (fifo_in_ready) begin
                        state <= ST_IDLE;
                        conv_busy_out <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    conv_busy_out <= 1'b0;
                end
            endcase
        end
    end

    assign fifo_in_valid = (state == ST_PUSH);

    result_fifo #(
        .WIDTH(`RES_W),
        .DEPTH(`RES_FIFO_DEPTH),
        .AW(`RES_FIFO_AW)
    ) u_result_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(sar_result),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

endmodule // adc_serial_if

/* File: sim/adc_serial_if_chk_sva.sv */
`include "adc_serial_regs.vh"
module adc_serial_if_chk (
    input wire clk_in,
    input wire sys_rst_in,
    input wire sel_n_in,
    input wire sclk_in,
    input wire chan_sel_in,
    input wire cmp_in,
    input wire data_out_out,
    input wire data_oe_out,
    input wire eoc_out,
    input wire [`CODE_W-1:0] chan_code_out,
    input wire [`NUM_CHANNELS-1:0] chan_onehot_out,
    input wire sample_out,
    input wire [`RES_W-1:0] dac_code_out,
    input wire conv_busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence sel_low_run;
        $fell(sel_n_in) ##1 !sel_n_in [*5];
    endsequence
    sequence handoff;
        $fell(eoc_out) ##0 $fell(sample_out);
    endsequence
    oe_on_a: assert property (sel_low_run |-> data_oe_out)
        else $error("output not enabled after select fall");
    oe_off_a: assert property (sel_n_in [*6] |-> !data_oe_out)
        else $error("output driven while deselected");
    code_hold_a: assert property (
        sel_n_in [*4] |=> $stable(chan_code_out))
        else $error("channel code moved while deselected");
    onehot_map_a: assert property ($changed(chan_code_out) |=>
        chan_onehot_out == ((chan_code_out < 4'hE) ?
        (14'h1 << chan_code_out) : 14'h0))
        else $error("multiplexer select does not match code");
    eoc_fall_a: assert property (
        $fell(eoc_out) |-> handoff and !data_out_out)
        else $error("tenth edge handoff wrong");
    conv_start_a: assert property (handoff |=>
        $rose(conv_busy_out) && dac_code_out == 10'h200)
        else $error("conversion did not start");
    conv_end_a: assert property ($rose(conv_busy_out) |->
        ##[20:100] $rose(eoc_out))
        else $error("end of conversion missing");
    eoc_busy_a: assert property (conv_busy_out |-> !eoc_out)
        else $error("end of conversion high while busy");
    dac_idle_a: assert property (!conv_busy_out && !$past(conv_busy_out)
        |-> dac_code_out == 10'h000)
        else $error("trial code nonzero while idle");
endmodule // adc_serial_if_chk
bind adc_serial_if adc_serial_if_chk u_adc_serial_if_chk (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .sel_n_in(sel_n_in), .sclk_in(sclk_in),
    .chan_sel_in(chan_sel_in), .cmp_in(cmp_in), .data_out_out(data_out_out),
    .data_oe_out(data_oe_out), .eoc_out(eoc_out),
    .chan_code_out(chan_code_out), .chan_onehot_out(chan_onehot_out),
    .sample_out(sample_out), .dac_code_out(dac_code_out),
    .conv_busy_out(conv_busy_out));

/* File: sim/host_port_model.sv */
module host_port_model (
    output logic sel_n_out,
    output logic sclk_out,
    output logic chan_sel_out,
    input wire data_in,
    input wire oe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b0;
        chan_sel_out = 1'b0;
    end
    // Clock stands low between frames; 10 to 16 clocks normally
    // Pins move a few ns after a system clock edge, never on it
    task automatic open_frame;
        #3 sel_n_out = 1'b0;
        #407;
    endtask
    task automatic close_frame;
        #200 sel_n_out = 1'b1;
        chan_sel_out = ~chan_sel_out; // Released line must not look stable
        #200;
    endtask
    task automatic burst(input logic [15:0] code, input int n,
                         output logic [15:0] rx, output logic drove);
        drove = 1'b1;
        rx = 16'h0000;
        #3;
        for (int i = 0; i < n; i++) begin
            chan_sel_out = code[15-i];
            #200 sclk_out = 1'b1;
            #200 rx = {rx[14:0], data_in};
            drove = drove & oe_in;
            sclk_out = 1'b0;
        end
    endtask
    task automatic xfer(input logic [15:0] code, input int n,
                        output logic [15:0] rx, output logic drove);
        open_frame();
        burst(code, n, rx, drove);
        close_frame();
    endtask
endmodule // host_port_model

/* File: sim/serial_adc_host_interface_test.sv */
module serial_adc_host_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [9:0] vin = 10'h000;
    logic [9:0] prev = 10'h000;
    logic [15:0] rx;
    logic drove;
    wire sel_n_in, sclk_in, chan_sel_in, data_out_out, data_oe_out, eoc_out;
    wire sample_out, conv_busy_out;
    wire [3:0] chan_code_out;
    wire [13:0] chan_onehot_out;
    wire [9:0] dac_code_out;
    wire cmp_in = (vin >= dac_code_out);
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 clk_in = ~clk_in;
    adc_serial_if u_adc_serial_if (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .sel_n_in(sel_n_in), .sclk_in(sclk_in), .chan_sel_in(chan_sel_in),
        .cmp_in(cmp_in), .data_out_out(data_out_out),
        .data_oe_out(data_oe_out), .eoc_out(eoc_out),
        .chan_code_out(chan_code_out), .chan_onehot_out(chan_onehot_out),
        .sample_out(sample_out), .dac_code_out(dac_code_out),
        .conv_busy_out(conv_busy_out));
    host_port_model u_host_port_model (.sel_n_out(sel_n_in),
        .sclk_out(sclk_in), .chan_sel_out(chan_sel_in),
        .data_in(data_out_out), .oe_in(data_oe_out));
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_eoc;
        int k;
        k = 0;
        while (eoc_out !== 1'b1 && k < 200) begin
            @(posedge clk_in);
            k++;
        end
        cmp_val(eoc_out, 1'b1);
    endtask
    task automatic test_reset;
        cmp_val({eoc_out, data_oe_out, conv_busy_out}, 3'h4);
        $display("test_reset done");
    endtask
    // Every code; each access reads back the previous result
    task automatic test_codes;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk_in) vin <= c * 61 + 7;
            u_host_port_model.xfer({c[3:0], 12'hFFF}, 10, rx, drove);
            cmp_val(rx, {6'h00, prev});
            cmp_val(drove, 1'b1);
            cmp_val(data_oe_out, 1'b0);
            cmp_val(eoc_out, 1'b0);
            cmp_val(chan_code_out, c[3:0]);
            cmp_val(chan_onehot_out, c < 14 ? 14'h1 << c : 14'h0);
            wait_eoc();
            prev = c * 61 + 7;
        end
        $display("test_codes done");
    endtask
    // Long access pads zeros; short access starts nothing
    task automatic test_lengths;
        @(posedge clk_in) vin <= 10'h2A5;
        u_host_port_model.xfer(16'h5A5A, 16, rx, drove);
        cmp_val(rx, {prev, 6'h00});
        cmp_val(chan_code_out, 4'h5);
        wait_eoc();
        u_host_port_model.xfer(16'h3000, 6, rx, drove);
        cmp_val(rx, 16'h002A);
        repeat (60) @(posedge clk_in);
        cmp_val(eoc_out, 1'b1);
        u_host_port_model.xfer(16'h9000, 10, rx, drove);
        cmp_val(rx, 16'h02A5);
        wait_eoc();
        $display("test_lengths done");
    endtask
    // Select held low over two accesses: MSB follows end of conversion
    task automatic test_continuous;
        @(posedge clk_in) vin <= 10'h15A;
        u_host_port_model.open_frame();
        u_host_port_model.burst(16'hB000, 10, rx, drove);
        cmp_val(rx, 16'h02A5);
        repeat (8) @(posedge clk_in);
        cmp_val(eoc_out, 1'b0);
        cmp_val(chan_code_out, 4'hB);
        wait_eoc();
        vin <= 10'h0C3;
        u_host_port_model.burst(16'h7000, 10, rx, drove);
        cmp_val(rx, 16'h015A);
        cmp_val(drove, 1'b1);
        cmp_val(chan_code_out, 4'h7);
        u_host_port_model.close_frame();
        wait_eoc();
        $display("test_continuous done");
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        test_reset();
        test_codes();
        test_lengths();
        test_continuous();
        stop_test();
    end
endmodule // serial_adc_host_interface_test
